// ===== rtl/dcr_config_regs.sv
`timescale 1ns/10ps
module dcr_config_regs
   import dcr_pkg::*;
(
   input  wire logic                    clk_i,          // core clock
   input  wire logic                    rst_b_i,        // async reset, low
   input  wire logic [15:0]             cfg_addr_i,     // register offset
   input  wire logic [15:0]             cfg_wdata_i,    // write data
   input  wire logic                    cfg_wr_i,       // write strobe
   input  wire logic                    cfg_rd_i,       // read strobe
   output logic [15:0]                  cfg_rdata_o,    // read data
   output logic                         cfg_rvalid_o,   // read data valid
   input  wire logic                    cal_mode_i,     // calibration running
   input  wire logic [3:0]              cal_load_i,     // cal strobe, ch1=b0
   input  wire dcr_pkg::dcr_gain_vec_t  cal_result_i,   // results, ch1=[0]
   output logic [3:0]                   chan_analog_clock_gate_o, // ch1=b0
   output logic                         core_clock_gate_o,        // core off
   output logic                         clock_sleep_o,            // sleep
   output logic                         clock_receiver_power_down_o, // pdn
   output logic                         receiver_power_save_o,    // power save
   output logic [3:0]                   chan_clock_invert_o,      // ch1=b0
   output logic [5:0]                   bandgap_trim_o,           // trim code
   output dcr_pkg::dcr_gain_vec_t       chan_gain_o               // applied
);
   import dcr_pkg::*;

   logic [15:0]        clock_control;
   logic [15:0]        next_clock_control;
   logic [15:0]        reference_trim;
   logic [15:0]        next_reference_trim;
   logic [15:0]        gain_value [NUM_CHAN];
   logic [NUM_CHAN-1:0] gain_hit;

   logic [15:0]        next_rdata;
   logic               next_rvalid;
   logic [3:0]         next_gate;
   logic               next_core_gate;
   logic               next_sleep;
   logic               next_pdn;
   logic               next_psave;
   logic [3:0]         next_invert;
   logic [5:0]         next_trim;
   dcr_gain_vec_t      next_gain;
   // offset decode
   logic               hit_clock_control;
   logic               hit_reference_trim;
   logic               hit_gain;
   logic [15:0]        gain_read;

   // one gain register per channel, channel one at the highest offset
   for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
      dcr_gain_if gif ();
      assign gain_hit[i]   = (cfg_addr_i ==
                              (ADDR_CHANNEL1_GAIN - 16'(i)));
      assign gif.wr        = cfg_wr_i && gain_hit[i];
      assign gif.wdata     = cfg_wdata_i;
      assign gif.cal_load  = cal_load_i[i];
      assign gif.cal_value = cal_result_i[i];
      assign gain_value[i] = gif.value;
      dcr_gain_reg u_gain (
         .clk_i   (clk_i),
         .rst_b_i (rst_b_i),
         .bus     (gif.chan)
      );
   end

   // one decode serves both strobes, so a read and a write of one
   // offset in the same cycle always agree on the target
   always_comb begin
      hit_clock_control  = 1'b0;
      hit_reference_trim = 1'b0;
      case (cfg_addr_i)
         ADDR_CLOCK_CONTROL: begin
            hit_clock_control = 1'b1;
         end
         ADDR_REFERENCE_TRIM: begin
            hit_reference_trim = 1'b1;
         end
         default: begin
            hit_clock_control  = 1'b0;
            hit_reference_trim = 1'b0;
         end
      endcase
   end

   // gain offsets never overlap, so at most one channel adds in
   always_comb begin
      hit_gain  = 1'b0;
      gain_read = 16'h0000;
      for (int i = 0; i < NUM_CHAN; i++) begin
         hit_gain  = hit_gain | gain_hit[i];
         gain_read = gain_read | (gain_hit[i] ? gain_value[i] : 16'h0000);
      end
   end

   // clock_control: all sixteen bits store, reserved ones included
   always_comb begin
      next_clock_control = clock_control;
      if (cfg_wr_i && hit_clock_control) begin
         next_clock_control = cfg_wdata_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         clock_control <= RST_CLOCK_CONTROL;
      end else begin
         clock_control <= next_clock_control;
      end
   end

   // reference_trim: only the low six bits reach the analog side
   always_comb begin
      next_reference_trim = reference_trim;
      if (cfg_wr_i && hit_reference_trim) begin
         next_reference_trim = cfg_wdata_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         reference_trim <= RST_REFERENCE_TRIM;
      end else begin
         reference_trim <= next_reference_trim;
      end
   end

   // read port; unmapped offsets read as zero and the data holds until
   // the next read. a read beside a write of the same offset sees the
   // old value, since the mux looks at the registers, not the bus
   always_comb begin
      next_rvalid = cfg_rd_i;
      next_rdata  = cfg_rdata_o;
      if (cfg_rd_i) begin
         if (hit_clock_control) begin
            next_rdata = clock_control;
         end else if (hit_reference_trim) begin
            next_rdata = reference_trim;
         end else if (hit_gain) begin
            next_rdata = gain_read;
         end else begin
            next_rdata = 16'h0000;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cfg_rdata_o  <= 16'h0000;
         cfg_rvalid_o <= 1'b0;
      end else begin
         cfg_rdata_o  <= next_rdata;
         cfg_rvalid_o <= next_rvalid;
      end
   end

   // clock tree controls; power-down overrides every gate so that no
   // clock is left running, whatever the gate bits say
   always_comb begin
      next_pdn       = clock_control[CC_PDN_BIT];
      next_sleep     = clock_control[CC_SLEEP_BIT];
      // power save trades falling-edge quality for receiver power
      next_psave     = clock_control[CC_PSAVE_BIT];
      next_core_gate = clock_control[CC_CORE_GATE_BIT] | next_pdn;
      for (int i = 0; i < NUM_CHAN; i++) begin
         next_gate[i]   = clock_control[CC_GATE_CH1_BIT - i]
                          | next_pdn;
         // no guard against power save: software keeps them apart
         next_invert[i] = clock_control[CC_INV_CH1_BIT - i];
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         chan_analog_clock_gate_o    <= 4'h0;
         core_clock_gate_o           <= 1'b0;
         clock_sleep_o               <= 1'b0;
         clock_receiver_power_down_o <= 1'b0;
         receiver_power_save_o       <= 1'b0;
         chan_clock_invert_o         <= 4'h0;
      end else begin
         chan_analog_clock_gate_o    <= next_gate;
         core_clock_gate_o           <= next_core_gate;
         clock_sleep_o               <= next_sleep;
         clock_receiver_power_down_o <= next_pdn;
         receiver_power_save_o       <= next_psave;
         chan_clock_invert_o         <= next_invert;
      end
   end

   // analog controls: reference trim and the applied gain per channel
   always_comb begin
      for (int i = 0; i < NUM_CHAN; i++) begin
         // gain held at zero while calibration owns the channel
         next_gain[i] = cal_mode_i ? '0
                        : gain_value[i][GN_SET_LSB +: GAIN_W];
      end
      next_trim = reference_trim[RT_TRIM_LSB +: TRIM_W];
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bandgap_trim_o <= 6'h00;
         chan_gain_o    <= '0;
      end else begin
         bandgap_trim_o <= next_trim;
         chan_gain_o    <= next_gain;
      end
   end
endmodule

// ===== rtl/dcr_pkg.sv
package dcr_pkg;
   localparam int unsigned    DATA_W      = 16;
   localparam int unsigned    ADDR_W      = 16;
   localparam int unsigned    NUM_CHAN    = 4;
   localparam int unsigned    GAIN_W      = 7;
   localparam int unsigned    TRIM_W      = 6;

   // register offsets
   localparam logic [15:0]    ADDR_CLOCK_CONTROL  = 16'h0002;
   localparam logic [15:0]    ADDR_REFERENCE_TRIM = 16'h0003;
   localparam logic [15:0]    ADDR_CHANNEL4_GAIN  = 16'h0004;
   localparam logic [15:0]    ADDR_CHANNEL1_GAIN  = 16'h0007;

   // reset values
   localparam logic [15:0]    RST_CLOCK_CONTROL   = 16'h0000;
   localparam logic [15:0]    RST_REFERENCE_TRIM  = 16'h0000;
   localparam logic [15:0]    RST_GAIN            = 16'h0000;

   // clock_control fields; gate bits: channel one at the top
   localparam int unsigned    CC_GATE_CH1_BIT     = 11;
   localparam int unsigned    CC_CORE_GATE_BIT    = 7;
   localparam int unsigned    CC_SLEEP_BIT        = 6;
   localparam int unsigned    CC_PDN_BIT          = 5;
   localparam int unsigned    CC_PSAVE_BIT        = 4;
   localparam int unsigned    CC_INV_CH1_BIT      = 3;

   // reference_trim field
   localparam int unsigned    RT_TRIM_LSB         = 0;

   // gain register fields
   localparam int unsigned    GN_SET_LSB          = 0;
   localparam int unsigned    GN_CAL_LSB          = 8;
   localparam int unsigned    GN_RSVD_LO_BIT      = 7;
   localparam int unsigned    GN_RSVD_HI_BIT      = 15;

   typedef logic [GAIN_W-1:0] dcr_gain_t;
   typedef dcr_gain_t [NUM_CHAN-1:0] dcr_gain_vec_t;
endpackage

// ===== rtl/dcr_gain_if.sv
`timescale 1ns/10ps
interface dcr_gain_if;
   import dcr_pkg::*;
   logic              wr;
   logic [15:0]       wdata;
   logic              cal_load;
   dcr_gain_t         cal_value;
   logic [15:0]       value;

   modport ctrl (output wr, output wdata, output cal_load,
                 output cal_value, input value);
   modport chan (input wr, input wdata, input cal_load,
                 input cal_value, output value);
endinterface

// ===== rtl/dcr_gain_reg.sv
`timescale 1ns/10ps
module dcr_gain_reg (
   input  wire logic   clk_i,   // core clock
   input  wire logic   rst_b_i, // async reset, active low
   dcr_gain_if.chan    bus      // write and calibration side
);
   import dcr_pkg::*;

   logic [15:0]        gain_reg;
   logic [15:0]        next_gain_reg;

   always_comb begin
      next_gain_reg = gain_reg;
      if (bus.wr) begin
         // software owns setting and reserved bits only
         next_gain_reg[GN_SET_LSB +: GAIN_W] =
            bus.wdata[GN_SET_LSB +: GAIN_W];
         next_gain_reg[GN_RSVD_LO_BIT] = bus.wdata[GN_RSVD_LO_BIT];
         next_gain_reg[GN_RSVD_HI_BIT] = bus.wdata[GN_RSVD_HI_BIT];
      end
      if (bus.cal_load) begin
         next_gain_reg[GN_CAL_LSB +: GAIN_W] = bus.cal_value;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         gain_reg <= RST_GAIN;
      end else begin
         gain_reg <= next_gain_reg;
      end
   end

   assign bus.value = gain_reg;
endmodule

// ===== sim/dcr_config_regs_sva.sv
`timescale 1ns/10ps
module dcr_config_regs_sva
   import dcr_pkg::*;
(
   input  wire logic                   clk_i,                       // clock
   input  wire logic                   rst_b_i,                     // reset
   input  wire logic [15:0]            cfg_addr_i,                  // offset
   input  wire logic [15:0]            cfg_wdata_i,                 // wdata
   input  wire logic                   cfg_wr_i,                    // write
   input  wire logic                   cfg_rd_i,                    // read
   input  wire logic [15:0]            cfg_rdata_o,                 // rdata
   input  wire logic                   cfg_rvalid_o,                // rvalid
   input  wire logic                   cal_mode_i,                  // cal mode
   input  wire logic [3:0]             chan_analog_clock_gate_o,    // gates
   input  wire logic                   core_clock_gate_o,           // core
   input  wire logic                   clock_sleep_o,               // sleep
   input  wire logic                   clock_receiver_power_down_o, // pdn
   input  wire logic                   receiver_power_save_o,       // psave
   input  wire logic [3:0]             chan_clock_invert_o,         // invert
   input  wire logic [5:0]             bandgap_trim_o,              // trim
   input  wire dcr_pkg::dcr_gain_vec_t chan_gain_o                  // gain
);
   logic [15:0] cc;
   logic [15:0] cq;
   // shadow of clock_control and of the output stage one edge behind it
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cc <= '0;
         cq <= '0;
      end else begin
         if (cfg_wr_i && cfg_addr_i == 16'h0002) cc <= cfg_wdata_i;
         cq <= cc;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence trim_wr;
      cfg_wr_i && cfg_addr_i == 16'h0003;
   endsequence
   sequence rd_unmapped;
      cfg_rd_i && (cfg_addr_i < 16'h0002 || cfg_addr_i > 16'h0007);
   endsequence
   chan_gate_a: assert property (
      chan_analog_clock_gate_o ==
         ({cq[8], cq[9], cq[10], cq[11]} | {4{cq[5]}}))
      else $error("channel gate mismatch");
   core_gate_a: assert property (
      core_clock_gate_o == (cq[7] | cq[5])) else $error("core gate mismatch");
   clock_sleep_a: assert property (
      clock_sleep_o == cq[6]) else $error("sleep mismatch");
   power_down_a: assert property (
      clock_receiver_power_down_o == cq[5]) else $error("pdn mismatch");
   power_save_a: assert property (
      receiver_power_save_o == cq[4]) else $error("psave mismatch");
   clock_invert_a: assert property (
      chan_clock_invert_o == {cq[0], cq[1], cq[2], cq[3]})
      else $error("invert mismatch");
   trim_update_a: assert property (
      trim_wr |-> ##2 bandgap_trim_o == 6'($past(cfg_wdata_i, 2)))
      else $error("trim mismatch");
   gain_cal_a: assert property (
      cal_mode_i |=> chan_gain_o == '0) else $error("gain not zero");
   read_valid_a: assert property (
      ##1 cfg_rvalid_o == $past(cfg_rd_i)) else $error("rvalid timing");
   unmapped_zero_a: assert property (
      rd_unmapped |=> cfg_rdata_o == 16'h0000) else $error("unmapped read");
endmodule
bind dcr_config_regs dcr_config_regs_sva u_sva (.*);

// ===== sim/tb.sv
`timescale 1ns/10ps
module tb;
   import dcr_pkg::*;
   logic          clk_i = 0;
   logic          rst_b_i = 0;
   logic [15:0]   addr = '0;
   logic [15:0]   wdata = '0;
   logic          wr = 0;
   logic          rd = 0;
   logic          cal_mode = 0;
   logic [3:0]    cal_load = '0;
   dcr_gain_vec_t cal_res = '0;
   logic [15:0]   rdata;
   logic          rvalid;
   logic [3:0]    gate;
   logic          core;
   logic          sleep;
   logic          pdn;
   logic          psave;
   logic [3:0]    inv;
   logic [5:0]    trim;
   dcr_gain_vec_t gain;
   logic [11:0]   outs;
   int            err_total = 0;
   int            samples_checked = 0;
   // outputs laid out in clock_control bit order
   assign outs = {gate[0], gate[1], gate[2], gate[3], core, sleep, pdn,
                  psave, inv[0], inv[1], inv[2], inv[3]};
   always #2 clk_i = ~clk_i;
   dcr_config_regs uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .cfg_addr_i(addr),
      .cfg_wdata_i(wdata), .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_rdata_o(rdata),
      .cfg_rvalid_o(rvalid), .cal_mode_i(cal_mode), .cal_load_i(cal_load),
      .cal_result_i(cal_res), .chan_analog_clock_gate_o(gate),
      .core_clock_gate_o(core), .clock_sleep_o(sleep),
      .clock_receiver_power_down_o(pdn), .receiver_power_save_o(psave),
      .chan_clock_invert_o(inv), .bandgap_trim_o(trim), .chan_gain_o(gain));
   task automatic wrap_up;
      if (err_total == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(string s, logic [15:0] e, logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s exp %h got %h", s, e, g);
      end
   endtask
   // returns two edges after the strobe, when control outputs have settled
   task automatic wr_reg(logic [15:0] a, logic [15:0] d);
      addr = a;
      wdata = d;
      wr = 1;
      @(negedge clk_i);
      wr = 0;
      @(negedge clk_i);
   endtask
   task automatic rd_reg(logic [15:0] a, logic [15:0] e);
      int n;
      addr = a;
      rd = 1;
      @(negedge clk_i);
      rd = 0;
      for (n = 0; n < 4 && rvalid !== 1'b1; n++) @(negedge clk_i);
      if (n == 4) begin
         err_total++;
         $display("CHECK FAILED rvalid exp 1 got %b", rvalid);
         wrap_up();
      end else begin
         chk($sformatf("reg %h", a), e, rdata);
         // let an edge pass so that a following read raises rd afresh
         @(negedge clk_i);
      end
   endtask
   initial begin
      repeat (20) @(negedge clk_i);
      rst_b_i = 1;
      for (int a = 2; a < 8; a++) rd_reg(16'(a), 16'h0000);
      // one bit at a time keeps invert and power save apart
      for (int i = 0; i < 12; i++) begin
         wr_reg(16'h0002, 16'h0001 << i);
         rd_reg(16'h0002, 16'h0001 << i);
         chk("clk outs", i == 5 ? 16'h0fa0 : 16'h1 << i, {4'h0, outs});
      end
      wr_reg(16'h0003, 16'h5a65);
      rd_reg(16'h0003, 16'h5a65);
      chk("trim", 16'h0025, {10'h0, trim});
      for (int n = 1; n < 5; n++) begin
         wr_reg(16'(8 - n), 16'hffc0 | 16'(n));
         rd_reg(16'(8 - n), 16'h80c0 | 16'(n));
         chk("gain", 16'h0040 | 16'(n), {9'h0, gain[n-1]});
      end
      cal_res[0] = 7'h55;
      cal_res[3] = 7'h2a;
      cal_load = 4'h9;
      @(negedge clk_i);
      cal_load = 4'h0;
      rd_reg(16'h0007, 16'hd5c1);
      rd_reg(16'h0004, 16'haac4);
      cal_mode = 1;
      @(negedge clk_i);
      chk("gain in cal", 16'h0000, {9'h0, gain[0]});
      cal_mode = 0;
      @(negedge clk_i);
      chk("gain after cal", 16'h0041, {9'h0, gain[0]});
      wr_reg(16'h0008, 16'hffff);
      rd_reg(16'h0008, 16'h0000);
      rd_reg(16'h0000, 16'h0000);
      rd_reg(16'h0002, 16'h0800);
      wrap_up();
   end
endmodule
